// ---- design/parallel_io_adapter_core.sv ----
`timescale 1ns/1ps
// ****************************************
// ****************************************
module parallel_io_adapter_core (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic master_reset_n,
  input wire logic enable_strobe,
  input wire logic rw,
  input wire logic chip_select_hi_first,
  input wire logic chip_select_hi_second,
  input wire logic chip_select_lo_n,
  input wire logic reg_select_low_bit,
  input wire logic reg_select_high_bit,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe_n,
  output logic irq_out_side_a_n,
  output logic irq_out_side_a_n_oe_n,
  output logic irq_out_side_b_n,
  output logic irq_out_side_b_n_oe_n,
  input wire logic ctl_input_a,
  input wire logic ctl_line_a_in,
  output logic ctl_line_a_out,
  output logic ctl_line_a_oe_n,
  input wire logic ctl_input_b,
  input wire logic ctl_line_b_in,
  output logic ctl_line_b_out,
  output logic ctl_line_b_oe_n,
  input wire logic [7:0] port_a_pins_in,
  output logic [7:0] port_a_pins_out,
  output logic [7:0] port_a_pins_oe_n,
  input wire logic [7:0] port_b_pins_in,
  output logic [7:0] port_b_pins_out,
  output logic [7:0] port_b_pins_oe_n
);

  pio_pkg::pin_sample_s raw;
  pio_pkg::pin_sample_s meta_q;
  pio_pkg::pin_sample_s sync_q;
  pio_pkg::bus_req_s req;
  pio_pkg::side_stat_s stat_a;
  pio_pkg::side_stat_s stat_b;
  logic e_d_q;
  logic e_fall;
  logic clr_n;
  logic wr_stb;
  logic rd_stb;
  logic acc_a;
  logic acc_b;
  logic ctl_wr_a;
  logic ctl_wr_b;
  logic data_rd_a;
  logic data_rd_b;
  logic [7:0] out_a_q;
  logic [7:0] dir_a_q;
  logic [7:0] out_b_q;
  logic [7:0] dir_b_q;
  logic [7:0] rd_val;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic chip_selected(
    input logic hi1,
    input logic hi2,
    input logic lo_n
  );
    return hi1 & hi2 & ~lo_n;
  endfunction : chip_selected

  // register file read mux
  function automatic logic [7:0] read_value(
    input logic [1:0] rs,
    input logic [7:0] ctl_a,
    input logic [7:0] ctl_b,
    input logic [7:0] pa,
    input logic [7:0] pb,
    input logic [7:0] dir_a,
    input logic [7:0] out_b,
    input logic [7:0] dir_b
  );
    logic [7:0] v;
    v = ctl_b;
    case (rs)
      pio_pkg::RS_DATA_A: begin
        // pins only: a loaded output may read back wrong
        v = ctl_a[pio_pkg::CTL_DIR_ACC] ? pa : dir_a;
      end
      pio_pkg::RS_CTL_A: begin
        v = ctl_a;
      end
      pio_pkg::RS_DATA_B: begin
        v = ctl_b[pio_pkg::CTL_DIR_ACC]
          ? ((out_b & dir_b) | (pb & ~dir_b)) : dir_b;
      end
      default: begin
        v = ctl_b;
      end
    endcase
    return v;
  endfunction : read_value

  // ****************************************
  // pin synchroniser
  // ****************************************
  assign raw = {enable_strobe, rw, chip_select_hi_first,
    chip_select_hi_second, chip_select_lo_n, reg_select_high_bit,
    reg_select_low_bit, master_reset_n, ctl_input_a, ctl_line_a_in,
    ctl_input_b, ctl_line_b_in, host_data_bus_in, port_a_pins_in,
    port_b_pins_in};

  // two flops on every pin but ref_clk and resetn before any logic
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta_q <= pio_pkg::SYNC_RESET;
      sync_q <= pio_pkg::SYNC_RESET;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end

  // strobe edge; all transfers finish on its trailing edge
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      e_d_q <= 1'h0;
    end else begin
      e_d_q <= sync_q.e;
    end
  end

  assign e_fall = e_d_q & ~sync_q.e;
  assign clr_n = resetn & sync_q.mrst_n;

  // ****************************************
  // host access decode
  // ****************************************
  // selects must hold through the strobe, so sampling at its end is safe
  assign req.sel = chip_selected(sync_q.cs_hi1, sync_q.cs_hi2,
    sync_q.cs_lo_n);
  assign req.rw = sync_q.rw;
  assign req.rs = {sync_q.rs1, sync_q.rs0};
  assign wr_stb = e_fall & req.sel & ~req.rw;
  assign rd_stb = e_fall & req.sel & req.rw;
  assign acc_a = stat_a.ctl[pio_pkg::CTL_DIR_ACC];
  assign acc_b = stat_b.ctl[pio_pkg::CTL_DIR_ACC];
  assign ctl_wr_a = wr_stb & (req.rs == pio_pkg::RS_CTL_A);
  assign ctl_wr_b = wr_stb & (req.rs == pio_pkg::RS_CTL_B);
  assign data_rd_a = rd_stb & (req.rs == pio_pkg::RS_DATA_A) & acc_a;
  assign data_rd_b = rd_stb & (req.rs == pio_pkg::RS_DATA_B) & acc_b;

  assign rd_val = read_value(req.rs, stat_a.ctl, stat_b.ctl, sync_q.pa,
    sync_q.pb, dir_a_q, out_b_q, dir_b_q);

  // ****************************************
  // data and direction registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!clr_n) begin
      out_a_q <= pio_pkg::REG_RESET;
      dir_a_q <= pio_pkg::REG_RESET;
      out_b_q <= pio_pkg::REG_RESET;
      dir_b_q <= pio_pkg::REG_RESET;
    end else if (wr_stb) begin
      case (req.rs)
        pio_pkg::RS_DATA_A: begin
          if (acc_a) begin
            out_a_q <= sync_q.hd;
          end else begin
            dir_a_q <= sync_q.hd;
          end
        end
        pio_pkg::RS_DATA_B: begin
          if (acc_b) begin
            out_b_q <= sync_q.hd;
          end else begin
            dir_b_q <= sync_q.hd;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // host data bus drive
  // ****************************************
  // live value: port A inputs track the pins during the read
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      host_data_bus_out <= pio_pkg::REG_RESET;
      host_data_bus_oe_n <= pio_pkg::OE_OFF;
    end else begin
      host_data_bus_out <= rd_val;
      host_data_bus_oe_n <= ~(sync_q.e & req.sel & req.rw);
    end
  end

  // ****************************************
  // peripheral port drive
  // ****************************************
  // lines with direction zero float; port A pull-up is external
  always_ff @(posedge ref_clk) begin
    if (!clr_n) begin
      port_a_pins_out <= pio_pkg::REG_RESET;
      port_a_pins_oe_n <= ~pio_pkg::REG_RESET;
      port_b_pins_out <= pio_pkg::REG_RESET;
      port_b_pins_oe_n <= ~pio_pkg::REG_RESET;
    end else begin
      port_a_pins_out <= out_a_q;
      port_a_pins_oe_n <= ~dir_a_q;
      port_b_pins_out <= out_b_q;
      port_b_pins_oe_n <= ~dir_b_q;
    end
  end

  // requests only ever pull low, never drive high
  always_ff @(posedge ref_clk) begin
    if (!clr_n) begin
      irq_out_side_a_n <= 1'h0;
      irq_out_side_a_n_oe_n <= pio_pkg::OE_OFF;
      irq_out_side_b_n <= 1'h0;
      irq_out_side_b_n_oe_n <= pio_pkg::OE_OFF;
      ctl_line_a_out <= 1'h0;
      ctl_line_a_oe_n <= pio_pkg::OE_OFF;
      ctl_line_b_out <= 1'h0;
      ctl_line_b_oe_n <= pio_pkg::OE_OFF;
    end else begin
      irq_out_side_a_n <= 1'h0;
      irq_out_side_a_n_oe_n <= ~stat_a.irq;
      irq_out_side_b_n <= 1'h0;
      irq_out_side_b_n_oe_n <= ~stat_b.irq;
      ctl_line_a_out <= stat_a.line_out;
      ctl_line_a_oe_n <= ~stat_a.line_oe;
      ctl_line_b_out <= stat_b.line_out;
      ctl_line_b_oe_n <= ~stat_b.line_oe;
    end
  end

  // ****************************************
  // side units
  // ****************************************
  side_event_unit side_a (
    .ref_clk(ref_clk),
    .clr_n(clr_n),
    .e_fall(e_fall),
    .sel(req.sel),
    .ctl_wr(ctl_wr_a),
    .wr_data(sync_q.hd),
    .data_rd(data_rd_a),
    .in_lvl(sync_q.in_a),
    .line_lvl(sync_q.line_a),
    .stat(stat_a)
  );

  side_event_unit side_b (
    .ref_clk(ref_clk),
    .clr_n(clr_n),
    .e_fall(e_fall),
    .sel(req.sel),
    .ctl_wr(ctl_wr_b),
    .wr_data(sync_q.hd),
    .data_rd(data_rd_b),
    .in_lvl(sync_q.in_b),
    .line_lvl(sync_q.line_b),
    .stat(stat_b)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_bus_released:
    assert property (!(sync_q.e && req.sel && req.rw) |=> host_data_bus_oe_n)
    else $error("host bus driven outside a selected read");

  a_bus_driven:
    assert property (sync_q.e && req.sel && req.rw |=> !host_data_bus_oe_n)
    else $error("host bus not driven during read");

  a_dir_a_write:
    assert property (clr_n && wr_stb && req.rs == pio_pkg::RS_DATA_A && !acc_a
      |=> dir_a_q == $past(sync_q.hd))
    else $error("direction A write lost");

  a_desel_no_write:
    assert property (clr_n && e_fall && !req.sel
      |=> $stable(out_a_q) && $stable(dir_b_q))
    else $error("register changed while deselected");

  a_port_a_read:
    assert property (req.rs == pio_pkg::RS_DATA_A && acc_a
      |=> host_data_bus_out == $past(sync_q.pa))
    else $error("port A read is not the pin level");

  a_port_b_read:
    assert property (req.rs == pio_pkg::RS_DATA_B && acc_b
      |=> host_data_bus_out == (($past(out_b_q) & $past(dir_b_q))
        | ($past(sync_q.pb) & ~$past(dir_b_q))))
    else $error("port B read mixes wrong sources");

  a_port_b_float:
    assert property (clr_n && !dir_b_q[0] ##1 clr_n && !dir_b_q[0]
      |-> port_b_pins_oe_n[0])
    else $error("port B input line driven");

  a_master_clear:
    assert property (!sync_q.mrst_n |=> dir_a_q == pio_pkg::REG_RESET
      && out_b_q == pio_pkg::REG_RESET && stat_a.ctl == pio_pkg::REG_RESET)
    else $error("master reset left a register set");

  a_irq_pin:
    assert property (stat_a.irq ##1 stat_a.irq |-> !irq_out_side_a_n_oe_n
      && !irq_out_side_a_n)
    else $error("request A not pulled low");

endmodule : parallel_io_adapter_core

// ---- design/side_event_unit.sv ----
`timescale 1ns/1ps
// ****************************************
// one side: control word, flags, request
// ****************************************
module side_event_unit (
  input wire logic ref_clk,
  input wire logic clr_n,
  input wire logic e_fall,
  input wire logic sel,
  input wire logic ctl_wr,
  input wire logic [7:0] wr_data,
  input wire logic data_rd,
  input wire logic in_lvl,
  input wire logic line_lvl,
  output pio_pkg::side_stat_s stat
);

  logic [5:0] ctl_q;
  logic f1_q;
  logic f2_q;
  logic armed_q;
  logic in_prev_q;
  logic line_prev_q;
  logic irq_q;
  logic set1;
  logic set2;

  // active edge seen between two strobe samples
  assign set1 = e_fall & armed_q & (in_lvl ^ in_prev_q)
    & (in_lvl == ctl_q[pio_pkg::CTL_IN_EDGE]);
  assign set2 = e_fall & armed_q & ~ctl_q[pio_pkg::CTL_LINE_MODE]
    & (line_lvl ^ line_prev_q)
    & (line_lvl == ctl_q[pio_pkg::CTL_LINE_EDGE]);

  // writable low six bits only
  always_ff @(posedge ref_clk) begin
    if (!clr_n) begin
      ctl_q <= pio_pkg::CTL_RESET;
    end else if (ctl_wr) begin
      ctl_q <= wr_data[5:0];
    end
  end

  // flags: a set in the clearing cycle wins
  always_ff @(posedge ref_clk) begin
    if (!clr_n) begin
      f1_q <= 1'h0;
      f2_q <= 1'h0;
    end else begin
      if (set1) begin
        f1_q <= 1'h1;
      end else if (data_rd) begin
        f1_q <= 1'h0;
      end
      if (set2) begin
        f2_q <= 1'h1;
      end else if (data_rd) begin
        f2_q <= 1'h0;
      end
    end
  end

  // re-arm only after a strobe with the part deselected
  always_ff @(posedge ref_clk) begin
    if (!clr_n) begin
      armed_q <= pio_pkg::ARM_RESET;
    end else if (data_rd) begin
      armed_q <= 1'h0;
    end else if (e_fall && !sel) begin
      armed_q <= 1'h1;
    end
  end

  // levels held at each strobe condition the edge sense
  always_ff @(posedge ref_clk) begin
    if (!clr_n) begin
      in_prev_q <= pio_pkg::LINE_IDLE;
      line_prev_q <= pio_pkg::LINE_IDLE;
    end else if (e_fall) begin
      in_prev_q <= in_lvl;
      line_prev_q <= line_lvl;
    end
  end

  // enables gate flags; late enable still raises request
  always_ff @(posedge ref_clk) begin
    if (!clr_n) begin
      irq_q <= 1'h0;
    end else begin
      irq_q <= (f1_q & ctl_q[pio_pkg::CTL_IN_EN])
        | (f2_q & ctl_q[pio_pkg::CTL_LINE_EN]
        & ~ctl_q[pio_pkg::CTL_LINE_MODE]);
    end
  end

  assign stat.ctl = {f1_q, f2_q, ctl_q};
  assign stat.irq = irq_q;
  assign stat.line_out = ctl_q[pio_pkg::CTL_LINE_EN];
  assign stat.line_oe = ctl_q[pio_pkg::CTL_LINE_MODE];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!clr_n);

  a_flag_clear_read:
    assert property (data_rd && !set1 |=> !f1_q)
    else $error("flag one survived a data read");

  a_rearm_gate:
    assert property (!armed_q |=> !$rose(f1_q) && !$rose(f2_q))
    else $error("flag set while not re-armed");

  a_edge_sets_flag:
    assert property (set1 |=> f1_q)
    else $error("active edge did not set flag one");

  a_irq_follows:
    assert property (f1_q && ctl_q[pio_pkg::CTL_IN_EN] |=> irq_q)
    else $error("enabled flag gave no request");

  a_irq_quiet:
    assert property (!(f1_q && ctl_q[0]) && !(f2_q && ctl_q[3]) |=> !irq_q)
    else $error("request without enabled flag");

  a_line_out_mode:
    assert property (ctl_q[pio_pkg::CTL_LINE_MODE] |=> !$rose(f2_q))
    else $error("flag two set while line is an output");

endmodule : side_event_unit

// ---- inc/pio_pkg.sv ----
// ****************************************
// shared constants and carriers
// ****************************************
package pio_pkg;

  // host data bus and port width
  localparam int DATA_W = 8;

  // register select codes
  localparam logic [1:0] RS_DATA_A = 2'h0;
  localparam logic [1:0] RS_CTL_A = 2'h1;
  localparam logic [1:0] RS_DATA_B = 2'h2;
  localparam logic [1:0] RS_CTL_B = 2'h3;

  // control word field positions
  localparam int CTL_IN_EN = 0;
  localparam int CTL_IN_EDGE = 1;
  localparam int CTL_DIR_ACC = 2;
  localparam int CTL_LINE_EN = 3;
  localparam int CTL_LINE_EDGE = 4;
  localparam int CTL_LINE_MODE = 5;
  localparam int CTL_FLAG2 = 6;
  localparam int CTL_FLAG1 = 7;
  localparam int CTL_RW_W = 6;

  // values after reset
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [5:0] CTL_RESET = 6'h00;
  localparam logic LINE_IDLE = 1'h1;
  localparam logic ARM_RESET = 1'h1;
  localparam logic OE_OFF = 1'h1;

  // pins seen through the synchroniser
  typedef struct packed {
    logic e;
    logic rw;
    logic cs_hi1;
    logic cs_hi2;
    logic cs_lo_n;
    logic rs1;
    logic rs0;
    logic mrst_n;
    logic in_a;
    logic line_a;
    logic in_b;
    logic line_b;
    logic [7:0] hd;
    logic [7:0] pa;
    logic [7:0] pb;
  } pin_sample_s;

  localparam pin_sample_s SYNC_RESET = 36'h0_0000_0000;

  // decoded host access
  typedef struct packed {
    logic sel;
    logic rw;
    logic [1:0] rs;
  } bus_req_s;

  // what one side hands back to the core
  typedef struct packed {
    logic [7:0] ctl;
    logic irq;
    logic line_out;
    logic line_oe;
  } side_stat_s;

endpackage : pio_pkg

// ---- verif/host_bus_model.sv ----
`timescale 1ns/1ps
// ****************************************
// host bus partner
// ****************************************
module host_bus_model (
  input wire logic ref_clk,
  input wire logic [7:0] host_data_bus_out,
  input wire logic host_data_bus_oe_n,
  output logic enable_strobe,
  output logic rw,
  output logic chip_select_hi_first,
  output logic chip_select_hi_second,
  output logic chip_select_lo_n,
  output logic reg_select_low_bit,
  output logic reg_select_high_bit,
  output logic [7:0] host_data_bus_in,
  output logic rd_stb
);
  logic [4:0] ph_q = 5'h00;
  logic [2:0] idle_sel [3] = '{3'b011, 3'b101, 3'b111};
  int n_idle = 0;

  // strobe never pauses: ten clocks low, ten high
  always @(negedge ref_clk) begin
    ph_q <= (ph_q == 5'h13) ? 5'h00 : ph_q + 5'h01;
  end
  assign enable_strobe = (ph_q >= 5'h0A);

  // idle bus never selects, so invalid cycles cannot reach the block
  initial begin
    {chip_select_hi_first, chip_select_hi_second, chip_select_lo_n} = 3'b011;
    {reg_select_high_bit, reg_select_low_bit} = 2'h0;
    rw = 1'b1;
    host_data_bus_in = 8'h5A;
    rd_stb = 1'b0;
  end

  task automatic wait_ph(input logic [4:0] p);
    do @(negedge ref_clk); while (ph_q != p);
  endtask : wait_ph

  // one access per strobe pulse; read data taken just as the strobe falls
  task automatic bus_op(input logic [2:0] sel, input logic rd, input logic [1:0] rs,
      input logic [7:0] wd, output logic [7:0] rdat, output logic oe_seen);
    wait_ph(5'h02);
    {chip_select_hi_first, chip_select_hi_second, chip_select_lo_n} = sel;
    {reg_select_high_bit, reg_select_low_bit} = rs;
    rw = rd;
    if (!rd) host_data_bus_in = wd;
    wait_ph(5'h13);
    rdat = host_data_bus_out;
    oe_seen = host_data_bus_oe_n;
    rd_stb = rd & (sel == 3'b110);
    @(negedge ref_clk);
    rd_stb = 1'b0;
    // held well past the fall, since the block sees pins through a synchroniser
    wait_ph(5'h05);
    {chip_select_hi_first, chip_select_hi_second, chip_select_lo_n} = idle_sel[n_idle];
    n_idle = (n_idle + 1) % 3;
    rw = 1'b1;
    host_data_bus_in = ~host_data_bus_in;
  endtask : bus_op
endmodule : host_bus_model

// ---- verif/tb.sv ----
`timescale 1ns/1ps
// ****************************************
// testbench top
// ****************************************
module tb;
  logic ref_clk = 1'b0;
  logic resetn, master_reset_n, enable_strobe, rw, rd_stb, host_data_bus_oe_n;
  logic chip_select_hi_first, chip_select_hi_second, chip_select_lo_n;
  logic reg_select_low_bit, reg_select_high_bit;
  logic [7:0] host_data_bus_in, host_data_bus_out;
  logic [7:0] port_a_pins_in, port_a_pins_out, port_a_pins_oe_n;
  logic [7:0] port_b_pins_in, port_b_pins_out, port_b_pins_oe_n;
  logic irq_out_side_a_n, irq_out_side_a_n_oe_n, irq_out_side_b_n, irq_out_side_b_n_oe_n;
  logic ctl_input_a, ctl_line_a_in, ctl_line_a_out, ctl_line_a_oe_n;
  logic ctl_input_b, ctl_line_b_in, ctl_line_b_out, ctl_line_b_oe_n;
  logic [1:0] lv_in, lv_ln, irq_w;
  logic [1:0][7:0] drv, load, dir_sh, out_sh, ctl_sh, poe, pout;
  logic [8:0] exp_q [$];
  int n_errors = 0;
  int checks = 0;

  always #10 ref_clk = ~ref_clk;

  // ****************************************
  // wires
  // ****************************************
  // requests pulled up; a loaded output line sags low
  assign poe = {port_b_pins_oe_n, port_a_pins_oe_n};
  assign pout = {port_b_pins_out, port_a_pins_out};
  assign port_a_pins_in = (port_a_pins_out & ~port_a_pins_oe_n & ~load[0]) | (drv[0] & port_a_pins_oe_n);
  assign port_b_pins_in = (port_b_pins_out & ~port_b_pins_oe_n & ~load[1]) | (drv[1] & port_b_pins_oe_n);
  assign ctl_line_a_in = ctl_line_a_oe_n ? lv_ln[0] : ctl_line_a_out;
  assign ctl_line_b_in = ctl_line_b_oe_n ? lv_ln[1] : ctl_line_b_out;
  assign {ctl_input_b, ctl_input_a} = lv_in;
  assign irq_w = {irq_out_side_b_n_oe_n | irq_out_side_b_n, irq_out_side_a_n_oe_n | irq_out_side_a_n};

  parallel_io_adapter_core i_parallel_io_adapter_core (
    .ref_clk, .resetn, .master_reset_n, .enable_strobe, .rw, .chip_select_hi_first,
    .chip_select_hi_second, .chip_select_lo_n, .reg_select_low_bit, .reg_select_high_bit,
    .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe_n, .irq_out_side_a_n,
    .irq_out_side_a_n_oe_n, .irq_out_side_b_n, .irq_out_side_b_n_oe_n, .ctl_input_a,
    .ctl_line_a_in, .ctl_line_a_out, .ctl_line_a_oe_n, .ctl_input_b, .ctl_line_b_in,
    .ctl_line_b_out, .ctl_line_b_oe_n, .port_a_pins_in, .port_a_pins_out, .port_a_pins_oe_n,
    .port_b_pins_in, .port_b_pins_out, .port_b_pins_oe_n
  );

  host_bus_model i_host_bus_model (
    .ref_clk, .host_data_bus_out, .host_data_bus_oe_n, .enable_strobe, .rw,
    .chip_select_hi_first, .chip_select_hi_second, .chip_select_lo_n,
    .reg_select_low_bit, .reg_select_high_bit, .host_data_bus_in, .rd_stb
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (exp_q.size() != 0) n_errors++;
    $display("checks %0d, n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // expected read value from the shadow copies and the pin drive
  function automatic logic [7:0] exp_reg(input logic [1:0] rs);
    logic s;
    s = rs[1];
    if (rs[0]) return ctl_sh[s];
    if (!ctl_sh[s][pio_pkg::CTL_DIR_ACC]) return dir_sh[s];
    if (s) return (out_sh[1] & dir_sh[1]) | (drv[1] & ~dir_sh[1]);
    return (out_sh[0] & dir_sh[0] & ~load[0]) | (drv[0] & ~dir_sh[0]);
  endfunction : exp_reg

  task automatic op(input logic [2:0] sel, input logic rd, input logic [1:0] rs,
      input logic [7:0] wd, output logic oe);
    logic [7:0] rv;
    i_host_bus_model.bus_op(sel, rd, rs, wd, rv, oe);
  endtask : op

  task automatic wr(input logic [1:0] rs, input logic [7:0] d);
    logic oe;
    if (rs[0]) ctl_sh[rs[1]] = d & 8'h3F;
    else if (ctl_sh[rs[1]][pio_pkg::CTL_DIR_ACC]) out_sh[rs[1]] = d;
    else dir_sh[rs[1]] = d;
    op(3'b110, 1'b0, rs, d, oe);
  endtask : wr

  // note the expected word; the monitor compares it when the read lands
  task automatic rd(input logic [1:0] rs, input logic [1:0] fl);
    logic oe;
    exp_q.push_back({1'b0, exp_reg(rs) | {fl, 6'h00}});
    op(3'b110, 1'b1, rs, 8'h00, oe);
  endtask : rd

  task automatic set_lv(input logic s, input logic sec, input logic v);
    if (sec) lv_ln[s] = v;
    else lv_in[s] = v;
  endtask : set_lv

  task automatic idle(input int n);
    repeat (n * 20) @(negedge ref_clk);
  endtask : idle

  task automatic chk_rst();
    ctl_sh = '0;
    dir_sh = '0;
    out_sh = '0;
    check({1'b0, port_a_pins_oe_n & port_b_pins_oe_n}, 9'h0FF);
    check({5'h0, ctl_line_a_oe_n, ctl_line_b_oe_n, irq_w}, 9'h00F);
    for (int r = 0; r < 4; r++) rd(2'(r), 2'h0);
  endtask : chk_rst

  // ****************************************
  // monitor and watchdog
  // ****************************************
  // a read must drive the bus with the noted word
  always @(posedge ref_clk) begin
    if (rd_stb === 1'b1) begin
      if (exp_q.size() == 0) check(9'h1FF, 9'h000);
      else check({host_data_bus_oe_n, host_data_bus_out}, exp_q.pop_front());
    end
  end

  // whole run is some six and a half thousand clocks
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    report_and_stop();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    logic s, sec, edg, en, oe;
    logic [7:0] cfg;
    logic [2:0] bad [3];
    bad = '{3'b010, 3'b100, 3'b111};
    resetn = 1'b0;
    master_reset_n = 1'b1;
    lv_in = 2'h3;
    lv_ln = 2'h3;
    drv = '0;
    load = '0;
    void'($urandom(32'hBC74));
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk_rst();
    // control word, direction and data per side; loading shows A's pin readback
    for (int k = 0; k < 2; k++) begin
      s = k[0];
      wr({s, 1'b1}, 8'hFF);
      rd({s, 1'b1}, 2'h0);
      check({7'h0, (s ? {ctl_line_b_oe_n, ctl_line_b_out} : {ctl_line_a_oe_n, ctl_line_a_out})}, 9'h001);
      wr({s, 1'b1}, 8'h00);
      wr({s, 1'b0}, 8'($urandom()));
      wr({s, 1'b1}, 8'h04);
      wr({s, 1'b0}, 8'($urandom()));
      drv[s] = 8'($urandom());
      rd({s, 1'b0}, 2'h0);
      check({1'b0, poe[s]}, {1'b0, ~dir_sh[s]});
      check({1'b0, pout[s]}, {1'b0, out_sh[s]});
      load[s] = 8'hFF;
      rd({s, 1'b0}, 2'h0);
      wr({s, 1'b1}, 8'h00);
      rd({s, 1'b0}, 2'h0);
      wr({s, 1'b1}, 8'h04);
    end
    // every side, input, edge and enable; late enable, clear, no re-set when busy
    for (int c = 0; c < 16; c++) begin
      s = c[3];
      sec = c[2];
      edg = c[1];
      en = c[0];
      cfg = sec ? {3'h0, edg, en, 3'h4} : {5'h0, 1'b1, edg, en};
      wr({s, 1'b1}, cfg);
      set_lv(s, sec, ~edg);
      idle(2);
      set_lv(s, sec, edg);
      idle(2);
      rd({s, 1'b1}, {~sec, sec});
      check({8'h0, irq_w[s]}, {8'h0, ~en});
      if (!en) begin
        wr({s, 1'b1}, cfg | (sec ? 8'h08 : 8'h01));
        idle(1);
        check({8'h0, irq_w[s]}, 9'h000);
      end
      // an active edge between the clearing read and the deselected strobe is swallowed
      set_lv(s, sec, ~edg);
      rd({s, 1'b0}, 2'h0);
      set_lv(s, sec, edg);
      rd({s, 1'b1}, 2'h0);
      rd({s, 1'b1}, 2'h0);
      check({8'h0, irq_w[s]}, 9'h001);
    end
    // one select inactive: writes dropped, bus left floating
    foreach (bad[k]) begin
      op(bad[k], 1'b0, 2'h1, 8'h2A, oe);
      op(bad[k], 1'b1, 2'h1, 8'h00, oe);
      check({8'h0, oe}, 9'h001);
    end
    rd(2'h1, 2'h0);
    // master reset in mid-run
    master_reset_n = 1'b0;
    repeat (30) @(negedge ref_clk);
    master_reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk_rst();
    report_and_stop();
  end
endmodule : tb
